// >>> core/epsc_power_ctrl.sv
// Power state sequencer for an Ethernet controller with integrated PHY
`timescale 1ns/1ps
`include "epsc_consts.svh"

module epsc_power_ctrl
  import epsc_pkg::*;
#(
  parameter int READY_CYC = `EPSC_READY_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pm_write,
  input wire logic [1:0] pm_write_data,
  input wire logic byte_test_write,
  input wire logic other_write,
  input wire logic other_read,
  input wire logic wake_source_clear,
  input wire logic pme_status_clear,
  input wire logic energy_on_clear,
  input epsc_wake_cfg_s wake_cfg,
  input epsc_phy_ctrl_s phy_ctrl,
  input wire logic wake_frame_detect,
  input wire logic remote_wake_detect,
  input wire logic line_energy_present,
  output logic [1:0] power_state_select,
  output logic [1:0] wake_source_status,
  output logic ready,
  output logic pme_status,
  output logic pme_irq,
  output logic wake_pin,
  output logic access_refused,
  output logic wake_detect_enable,
  output epsc_clk_gate_s clk_gate,
  output epsc_phy_stat_s phy_stat
);

  localparam logic [`EPSC_CNT_W-1:0] READY_C =
    `EPSC_CNT_W'(READY_CYC);

  epsc_state_e state_r;
  epsc_state_e state_nxt;
  logic [`EPSC_CNT_W-1:0] rdy_cnt_r;
  logic waking_r;
  logic frame_evt;
  logic energy_evt;
  logic wake_evt;
  logic pme_active;
  logic src_active;
  logic [1:0] ws_nxt;

  // -----------------------------------------------------------
  // State selection
  // -----------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EPSC_ST_D0: begin
        if (pm_write && ready) begin
          if (pm_write_data == `EPSC_PM_D1) begin
            state_nxt = EPSC_ST_D1;
          end else if (pm_write_data == `EPSC_PM_D2) begin
            state_nxt = EPSC_ST_D2;
          end
        end
      end
      EPSC_ST_D1, EPSC_ST_D2: begin
        if (byte_test_write) begin
          state_nxt = EPSC_ST_D0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= EPSC_ST_D0;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      power_state_select <= `EPSC_PM_D0;
    end else if (state_r != EPSC_ST_D0 && byte_test_write) begin
      power_state_select <= `EPSC_PM_D0;
    end else if (state_r == EPSC_ST_D0 && state_nxt == EPSC_ST_D1) begin
      power_state_select <= `EPSC_PM_D1;
    end else if (state_r == EPSC_ST_D0 && state_nxt == EPSC_ST_D2) begin
      power_state_select <= `EPSC_PM_D2;
    end
  end

  // -----------------------------------------------------------
  // Ready indication
  // -----------------------------------------------------------
  // Ready is counted from the wake write and rises READY_CYC cycles after it is sampled.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b1;
      waking_r <= 1'b0;
      rdy_cnt_r <= '0;
    end else if (state_nxt != EPSC_ST_D0) begin
      ready <= 1'b0;
      waking_r <= 1'b0;
      rdy_cnt_r <= '0;
    end else if (state_r != EPSC_ST_D0) begin
      waking_r <= 1'b1;
      rdy_cnt_r <= '0;
    end else if (waking_r) begin
      if (rdy_cnt_r >= READY_C - `EPSC_CNT_W'(1)) begin
        ready <= 1'b1;
        waking_r <= 1'b0;
      end else begin
        rdy_cnt_r <= rdy_cnt_r + `EPSC_CNT_W'(1);
      end
    end
  end

  // Byte test writes and the status clears pass while not ready; other reads and writes and power control writes are refused
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      access_refused <= 1'b0;
    end else begin
      access_refused <= !ready && (other_read ||
        other_write || pm_write);
    end
  end

  // -----------------------------------------------------------
  // Clock gating
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clk_gate <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      unique case (state_nxt)
        EPSC_ST_D0: clk_gate <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        EPSC_ST_D1: clk_gate <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        EPSC_ST_D2: clk_gate <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      endcase
    end
  end

  // -----------------------------------------------------------
  // Wake detection
  // -----------------------------------------------------------
  // Level test on energy, so a carrier present at entry fires at once.
  assign wake_detect_enable = (state_r == EPSC_ST_D1);
  assign frame_evt = (state_r == EPSC_ST_D1) &&
    (wake_frame_detect || remote_wake_detect) &&
    wake_cfg.wake_lan_enable;
  assign energy_evt = (state_r == EPSC_ST_D2) && line_energy_present &&
    wake_cfg.energy_wake_enable &&
    wake_source_status != `EPSC_WS_ENERGY;
  assign wake_evt = frame_evt || energy_evt;

  always_comb begin
    ws_nxt = wake_source_status;
    if (wake_source_clear) begin
      ws_nxt = `EPSC_WS_NONE;
    end
    if (frame_evt) begin
      ws_nxt = `EPSC_WS_FRAME;
    end else if (energy_evt) begin
      ws_nxt = `EPSC_WS_ENERGY;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_source_status <= `EPSC_WS_NONE;
    end else begin
      wake_source_status <= ws_nxt;
    end
  end

  // -----------------------------------------------------------
  // Power event and status
  // -----------------------------------------------------------
  assign src_active =
    (wake_source_status == `EPSC_WS_FRAME && wake_cfg.wake_lan_enable) ||
    (wake_source_status == `EPSC_WS_ENERGY &&
     wake_cfg.energy_wake_enable);
  assign pme_active = src_active;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pme_status <= 1'b0;
    end else if (wake_evt || pme_active) begin
      pme_status <= 1'b1;
    end else if (pme_status_clear) begin
      pme_status <= 1'b0;
    end
  end

  // Independent of the pin enable and of the pin itself
  assign pme_irq = pme_status;

  epsc_wake_pin u_wake_pin (
    .sys_clk(sys_clk),
    .rst(rst),
    .wake_evt(wake_evt),
    .pin_enable(wake_cfg.wake_pin_enable),
    .pulse_mode(wake_cfg.wake_pin_pulse_mode),
    .source_active(src_active || wake_evt),
    .wake_pin(wake_pin)
  );

  epsc_phy_pwr u_phy_pwr (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctrl(phy_ctrl),
    .line_energy_present(line_energy_present),
    .energy_on_clear(energy_on_clear),
    .stat(phy_stat)
  );

endmodule // epsc_power_ctrl

// >>> core/epsc_consts.svh
// Constants for the Ethernet power state controller
`ifndef EPSC_CONSTS_SVH
`define EPSC_CONSTS_SVH

`define EPSC_CLK_MHZ 100
`define EPSC_PULSE_MS 50
`define EPSC_PULSE_CYC (`EPSC_PULSE_MS * 1000 * `EPSC_CLK_MHZ)
`define EPSC_READY_MS 2
`define EPSC_READY_CYC (`EPSC_READY_MS * 1000 * `EPSC_CLK_MHZ)
`define EPSC_PM_D0 2'h0
`define EPSC_PM_D1 2'h1
`define EPSC_PM_D2 2'h2
`define EPSC_WS_NONE 2'h0
`define EPSC_WS_ENERGY 2'h1
`define EPSC_WS_FRAME 2'h2
`define EPSC_CNT_W 23

`endif

// >>> core/epsc_pkg.sv
// Types for the Ethernet power state controller
package epsc_pkg;

  typedef enum logic [1:0] {
    EPSC_ST_D0,
    EPSC_ST_D1,
    EPSC_ST_D2
  } epsc_state_e;

  typedef struct packed {
    logic wake_lan_enable;
    logic energy_wake_enable;
    logic wake_pin_enable;
    logic wake_pin_pulse_mode;
  } epsc_wake_cfg_s;

  typedef struct packed {
    logic phy_clk_en;
    logic int_clk_en;
    logic mac_rx_pm_clk_en;
    logic mac_host_clk_en;
    logic phy_energy_powerdown;
  } epsc_clk_gate_s;

  typedef struct packed {
    logic general_powerdown;
    logic energy_detect_powerdown_bit;
    logic energy_on_int_enable;
  } epsc_phy_ctrl_s;

  typedef struct packed {
    logic phy_powered;
    logic phy_auto_reset;
    logic phy_tx_enable;
    logic energy_on_flag;
    logic phy_irq;
  } epsc_phy_stat_s;

endpackage

// >>> core/epsc_wake_pin.sv
// External wake pin driver, static or timed pulse
`timescale 1ns/1ps
`include "epsc_consts.svh"

module epsc_wake_pin
  import epsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wake_evt,
  input wire logic pin_enable,
  input wire logic pulse_mode,
  input wire logic source_active,
  output logic wake_pin
);

  localparam logic [`EPSC_CNT_W-1:0] PULSE_CYC =
    `EPSC_CNT_W'(`EPSC_PULSE_CYC);

  logic [`EPSC_CNT_W-1:0] cnt_r;
  logic active_r;

  // -----------------------------------------------------------
  // Pin state
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_r <= 1'b0;
      cnt_r <= '0;
    end else if (!pin_enable || !source_active) begin
      active_r <= 1'b0;
      cnt_r <= '0;
    end else if (wake_evt) begin
      active_r <= 1'b1;
      cnt_r <= PULSE_CYC;
    end else if (active_r && pulse_mode) begin
      if (cnt_r <= `EPSC_CNT_W'(1)) begin
        active_r <= 1'b0;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r - `EPSC_CNT_W'(1);
      end
    end
    // Static mode holds until a source or enable clears
  end

  assign wake_pin = active_r;

endmodule // epsc_wake_pin

// >>> core/epsc_phy_pwr.sv
// PHY general and energy-detect power-down behaviour
`timescale 1ns/1ps
`include "epsc_consts.svh"

module epsc_phy_pwr
  import epsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input epsc_phy_ctrl_s ctrl,
  input wire logic line_energy_present,
  input wire logic energy_on_clear,
  output epsc_phy_stat_s stat
);

  logic gen_pd_r;
  logic energy_r;
  logic flag_r;
  logic auto_rst_r;

  // -----------------------------------------------------------
  // General power-down and automatic reset
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gen_pd_r <= 1'b0;
      auto_rst_r <= 1'b0;
    end else begin
      gen_pd_r <= ctrl.general_powerdown;
      auto_rst_r <= gen_pd_r && !ctrl.general_powerdown;
    end
  end

  // -----------------------------------------------------------
  // Energy-on flag, set wins over clear
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      energy_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      energy_r <= line_energy_present;
      if (ctrl.energy_detect_powerdown_bit && line_energy_present &&
          !energy_r) begin
        flag_r <= 1'b1;
      end else if (energy_on_clear) begin
        flag_r <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------
  // Status
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat <= '0;
    end else begin
      stat.phy_powered <= !ctrl.general_powerdown &&
        (!ctrl.energy_detect_powerdown_bit ||
         line_energy_present);
      stat.phy_tx_enable <= !ctrl.general_powerdown &&
        (!ctrl.energy_detect_powerdown_bit ||
         line_energy_present);
      stat.phy_auto_reset <= auto_rst_r;
      stat.energy_on_flag <= flag_r;
      stat.phy_irq <= flag_r && ctrl.energy_on_int_enable;
    end
  end

endmodule // epsc_phy_pwr

// >>> testbench/epsc_power_ctrl_monitor.sv
// Concurrent checks on the power state sequencer ports
`timescale 1ns/1ps
module epsc_power_ctrl_monitor
  import epsc_pkg::*;
#(
  parameter int READY_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pm_write,
  input wire logic [1:0] pm_write_data,
  input wire logic byte_test_write,
  input wire logic other_write,
  input wire logic wake_source_clear,
  input wire logic wake_frame_detect,
  input wire logic line_energy_present,
  input epsc_wake_cfg_s wake_cfg,
  input wire logic [1:0] power_state_select,
  input wire logic [1:0] wake_source_status,
  input wire logic ready,
  input wire logic pme_status,
  input wire logic pme_irq,
  input wire logic wake_pin,
  input wire logic access_refused,
  input epsc_clk_gate_s clk_gate
);
  // Slack of two cycles covers the select update edge
  localparam int RDY_LIM = READY_CYC + 2;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_d1_req;
    pm_write && pm_write_data == 2'h1 && ready && power_state_select == 2'h0;
  endsequence
  sequence s_wake_req;
    byte_test_write && power_state_select != 2'h0;
  endsequence
  a_d1_entry: assert property (
    s_d1_req |=> power_state_select == 2'h1 && !ready)
    else $error("sleep entry wrong");
  a_d1_clocks: assert property (
    power_state_select == 2'h1 |-> clk_gate == 5'h1C)
    else $error("light sleep gating wrong");
  a_d2_clocks: assert property (
    power_state_select == 2'h2 |-> (clk_gate & 5'h0F) == 5'h01)
    else $error("deep sleep gating wrong");
  a_wake_return: assert property (
    s_wake_req |=> power_state_select == 2'h0 ##[0:RDY_LIM] ready)
    else $error("wake slow");
  a_frame_source: assert property (
    power_state_select == 2'h1 && wake_cfg.wake_lan_enable &&
    wake_frame_detect |=> wake_source_status == 2'h2)
    else $error("frame source wrong");
  a_pme_follow: assert property (
    wake_source_status == 2'h0 ##1 wake_source_status != 2'h0 |->
    pme_status && pme_irq)
    else $error("no event");
  a_energy_wake: assert property (
    power_state_select == 2'h2 && line_energy_present &&
    wake_cfg.energy_wake_enable && !byte_test_write &&
    wake_source_status == 2'h0 |=> wake_source_status == 2'h1)
    else $error("energy source wrong");
  a_pin_drop: assert property (
    !wake_cfg.wake_pin_enable || (wake_source_clear &&
    !wake_frame_detect && !line_energy_present) |=> !wake_pin)
    else $error("pin not dropped");
  a_static_hold: assert property (
    wake_pin && wake_cfg == 4'hE && !wake_source_clear &&
    wake_source_status != 2'h0 |=> wake_pin)
    else $error("static pin lost");
  a_access_refused: assert property (
    other_write && !ready |=> access_refused)
    else $error("access not refused");
endmodule // epsc_power_ctrl_monitor

bind epsc_power_ctrl epsc_power_ctrl_monitor #(.READY_CYC(READY_CYC))
  i_epsc_power_ctrl_monitor (.*);

// >>> testbench/epsc_host_model.sv
// Host CPU model issuing single-cycle register strobes
`timescale 1ns/1ps
module epsc_host_model (
  input wire logic sys_clk,
  input wire logic ready,
  output logic pm_write,
  output logic [1:0] pm_write_data,
  output logic byte_test_write,
  output logic other_write,
  output logic other_read,
  output logic wake_source_clear,
  output logic pme_status_clear
);
  initial begin
    {pm_write, byte_test_write, other_write, other_read} = 4'h0;
    {wake_source_clear, pme_status_clear, pm_write_data} = 4'h0;
  end
  // One strobe per call; data shows its inverse once released
  task strobe(input logic [5:0] m, input logic [1:0] d);
    @(posedge sys_clk);
    #1;
    {pm_write, byte_test_write, other_write, other_read} = m[5:2];
    {wake_source_clear, pme_status_clear} = m[1:0];
    pm_write_data = d;
    @(posedge sys_clk);
    #1;
    {pm_write, byte_test_write, other_write, other_read} = 4'h0;
    {wake_source_clear, pme_status_clear} = 2'h0;
    pm_write_data = ~d;
  endtask
  task wake(output int n);
    strobe(6'h10, 2'h0);
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      strobe(6'h04, 2'h0);
      n++;
    end
  endtask
endmodule // epsc_host_model

// >>> testbench/epsc_power_ctrl_tb.sv
// Self-checking bench for the power state sequencer
`timescale 1ns/1ps
module epsc_power_ctrl_tb;
  import epsc_pkg::*;
  localparam int RC = 20;
  logic sys_clk = 0;
  logic rst = 1;
  logic pm_write, byte_test_write, other_write, other_read, wake_source_clear;
  logic pme_status_clear, energy_on_clear, wake_frame_detect, remote_wake_detect;
  logic line_energy_present, ready, pme_status, pme_irq, wake_pin;
  logic access_refused, wake_detect_enable;
  logic [1:0] pm_write_data, power_state_select, wake_source_status;
  epsc_wake_cfg_s wake_cfg;
  epsc_phy_ctrl_s phy_ctrl;
  epsc_clk_gate_s clk_gate;
  epsc_phy_stat_s phy_stat;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  epsc_power_ctrl #(.READY_CYC(RC)) i_epsc_power_ctrl (.*);
  epsc_host_model i_epsc_host_model (.*);
  always #5 sys_clk = ~sys_clk;
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task wake_clear;
    i_epsc_host_model.wake(n);
    chk("wake_select", power_state_select, 8'h00);
    chk("ready_time", n <= RC / 2 + 2, 8'h01);
    wake_cfg = 4'h2;
    i_epsc_host_model.strobe(6'h02, 2'h0);
    tick(1);
    chk("src_clear", {wake_source_status, wake_pin}, 8'h00);
    i_epsc_host_model.strobe(6'h01, 2'h0);
    chk("pme_clear", pme_status, 8'h00);
  endtask
  initial begin
    wake_cfg = '0;
    phy_ctrl = '0;
    {wake_frame_detect, remote_wake_detect} = 2'h0;
    {line_energy_present, energy_on_clear} = 2'h0;
    tick(12);
    rst = 0;
    tick(1);
    chk("reset", {power_state_select, wake_source_status, ready},
      8'h01);
    $display("reset test done");
    wake_cfg = 4'hE;
    i_epsc_host_model.strobe(6'h20, 2'h1);
    chk("d1_entry", {power_state_select, ready, wake_detect_enable},
      8'h05);
    chk("d1_gate", clk_gate, 8'h1C);
    i_epsc_host_model.strobe(6'h08, 2'h0);
    chk("refused", {access_refused, power_state_select},
      8'h05);
    wake_frame_detect = 1;
    tick(1);
    wake_frame_detect = 0;
    chk("frame_evt", {wake_source_status, pme_status, pme_irq, wake_pin},
      8'h17);
    tick(5);
    chk("static_pin", wake_pin, 8'h01);
    i_epsc_host_model.strobe(6'h01, 2'h0);
    chk("pme_held", pme_status, 8'h01);
    wake_clear();
    $display("light sleep test done");
    phy_ctrl.energy_detect_powerdown_bit = 1;
    wake_cfg = 4'h4;
    // Waking packets carry no checked payload, so losing them is fine
    line_energy_present = 1;
    i_epsc_host_model.strobe(6'h20, 2'h2);
    chk("d2_entry", {power_state_select, ready}, 8'h04);
    chk("d2_gate", clk_gate & 5'h0F, 8'h01);
    tick(2);
    chk("energy_evt", {wake_source_status, pme_status, wake_pin},
      8'h06);
    wake_clear();
    phy_ctrl.energy_detect_powerdown_bit = 0;
    line_energy_present = 0;
    $display("deep sleep test done");
    // Pulse end lies 50 ms out, beyond this run; only its start is seen
    wake_cfg = 4'hB;
    i_epsc_host_model.strobe(6'h20, 2'h1);
    remote_wake_detect = 1;
    tick(1);
    remote_wake_detect = 0;
    tick(1);
    chk("pulse_pin", {wake_source_status, wake_pin},
      8'h05);
    wake_cfg.wake_lan_enable = 0;
    tick(2);
    chk("enable_drop", wake_pin, 8'h00);
    wake_clear();
    $display("pulse test done");
    phy_ctrl = 3'h4;
    tick(3);
    chk("phy_down", phy_stat.phy_powered, 8'h00);
    phy_ctrl = 3'h0;
    tick(2);
    // Automatic reset is a one-cycle pulse two edges after release
    chk("phy_auto_reset", phy_stat.phy_auto_reset, 8'h01);
    tick(1);
    chk("phy_up", {phy_stat.phy_powered, phy_stat.phy_auto_reset},
      8'h02);
    phy_ctrl = 3'h3;
    tick(3);
    chk("ed_down", {phy_stat.phy_powered, phy_stat.phy_tx_enable},
      8'h00);
    line_energy_present = 1;
    tick(3);
    chk("ed_on", {phy_stat.phy_powered, phy_stat.energy_on_flag,
      phy_stat.phy_irq}, 8'h07);
    line_energy_present = 0;
    energy_on_clear = 1;
    tick(1);
    energy_on_clear = 0;
    tick(1);
    chk("flag_clear", phy_stat.energy_on_flag, 8'h00);
    $display("phy test done");
    summarize();
  end
endmodule // epsc_power_ctrl_tb
